// ==== src/synth_cfg_device.sv ====
// Purpose: Device end: serial word receiver, access-select bank and test pin selector
// Assumes: Link pins and chip enable are asynchronous; lock and divider inputs are on CLK
// Notes:   Effective optional words follow the access bits one cycle later
//          Masked words are still stored; a later access bit
//          shows the last host copy one cycle later
//          Test pin lags selector and lock inputs by one cycle
//          Both loops leave reset powered down
//          Lock and divider inputs must be on CLK
`timescale 1ns/100ps
`include "synth_regs.svh"

module synth_cfg_device
(
	// Clock and reset
	input  wire logic                CLK,
	input  wire logic                NRST,
	// Serial link
	synth_link_if.dev                LINK,
	// Chip enable pin, asynchronous
	input  wire logic                CE,
	// Loop status, same clock
	input  wire logic                DLOCK_MAIN,
	input  wire logic                DLOCK_AUX,
	input  wire logic                ALOCK_MAIN,
	input  wire logic                ALOCK_AUX,
	input  wire logic [3:0]          DIV_PULSE,
	// Configuration out
	output logic [`WORD_MSB:0]       WORD3,
	output logic [`WORD_MSB:0]       WORD4,
	output logic [`WORD_MSB:0]       WORD5,
	output logic [`WORD_MSB:0]       WORD6,
	output logic [`WORD_MSB:0]       WORD7,
	output logic                     FRAC22,
	output logic                     MAIN_PD,
	output logic                     AUX_PD,
	// Test pin
	output logic                     TEST_LOCK_O,
	output logic                     TEST_LOCK_OE
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	// Registered state and its next value
	synth_pkg::dev_state_s q;
	synth_pkg::dev_state_s d;

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------

	// Receive, bank update and pin selection all derive from one copy of state
	always_comb
	begin
		logic [`WORD_MSB:0] w;
		logic               sclk_rise;
		logic               le_rise;
		logic [3:0]         sel;
		// Scratch values first, so no latch
		w = q.shift;
		sclk_rise = 1'b0;
		le_rise = 1'b0;
		sel = 4'h0;
		d = q;

		// Two-flop synchronisers; only stage 1 and 2 feed logic
		// Stage 0 may be metastable, so nothing reads it
		// Reset clears all stages, matching the idle low wires
		d.sclk_r = {q.sclk_r[1:0], LINK.sclk};
		d.sdat_r = {q.sdat_r[0], LINK.sdata};
		d.le_r = {q.le_r[1:0], LINK.le};
		d.ce_r = {q.ce_r[0], CE};
		sclk_rise = q.sclk_r[1] & ~q.sclk_r[2];
		le_rise = q.le_r[1] & ~q.le_r[2];

		// Shift MSB first on each serial clock rise
		// Data and clock pass equal stages, so setup is kept
		if (sclk_rise)
		begin
			d.shift = {q.shift[`WORD_MSB-1:0], q.sdat_r[1]};
		end

		// Word dispatch on latch; words are stored whatever the access bits say
		// No shift here: the host holds the clock low
		// while latch enable is high
		if (le_rise)
		begin
			unique case (synth_pkg::word_index(w[`CODE_MSB:0]))
				3'h0:
				begin
					// Chip enable low disables auto power-up
					if (q.w4[`W4_AUTO_PU] && q.ce_r[1])
					begin
						d.main_pd = 1'b0;
						d.aux_pd = 1'b0;
					end
				end
				// Power-down bits ride in the top bit
				3'h1: d.main_pd = w[`PD_BIT];
				3'h2: d.aux_pd = w[`PD_BIT];
				3'h3: d.w3 = w;
				3'h4: d.w4 = w;
				// Optional words kept even while masked
				3'h5: d.w5 = w;
				3'h6: d.w6 = w;
				3'h7: d.w7 = w;
			endcase
		end

		// Each optional word picks host copy or forced default on its own bit
		// One cycle of lag buys a clean flop output;
		// a cleared bit restores the default next edge
		d.e5 = q.w3[`ACC_WORD5] ? q.w5 : `DEF_WORD5;
		d.e6 = q.w3[`ACC_WORD6] ? q.w6 : `DEF_WORD6;
		d.e7 = q.w3[`ACC_WORD7] ? q.w7 : `DEF_WORD7;

		// Divider outputs halved by toggling on each pulse rise
		// Pulses share this clock, so no synchroniser;
		// a pulse must drop for a cycle or a rise is lost
		d.div_p = DIV_PULSE;
		d.div_t = q.div_t ^ (DIV_PULSE & ~q.div_p);

		// Test pin selector; open drain pulls low while unlocked
		// Open drain never drives high;
		// an outside pull-up gives the high level
		sel = q.w4[`W4_SEL_HI:`W4_SEL_LO];
		d.pin_o = 1'b0;
		d.pin_oe = 1'b1;
		unique case (sel)
			`SEL_HIZ:         d.pin_oe = 1'b0;
			`SEL_GP_HIGH:     d.pin_o = 1'b1;
			`SEL_GP_LOW:      d.pin_o = 1'b0;
			`SEL_DLD_BOTH:    d.pin_o = DLOCK_MAIN & DLOCK_AUX;
			`SEL_DLD_MAIN:    d.pin_o = DLOCK_MAIN;
			`SEL_DLD_AUX:     d.pin_o = DLOCK_AUX;
			// Released while locked
			`SEL_ALD_BOTH_OD: d.pin_oe = ~(ALOCK_MAIN & ALOCK_AUX);
			`SEL_ALD_MAIN_OD: d.pin_oe = ~ALOCK_MAIN;
			`SEL_ALD_AUX_OD:  d.pin_oe = ~ALOCK_AUX;
			`SEL_ALD_BOTH_PP: d.pin_o = ALOCK_MAIN & ALOCK_AUX;
			`SEL_ALD_MAIN_PP: d.pin_o = ALOCK_MAIN;
			`SEL_ALD_AUX_PP:  d.pin_o = ALOCK_AUX;
			// Toggles of the previous cycle
			`SEL_AUX_REF:     d.pin_o = q.div_t[0];
			`SEL_AUX_FB:      d.pin_o = q.div_t[1];
			`SEL_MAIN_REF:    d.pin_o = q.div_t[2];
			`SEL_MAIN_FB:     d.pin_o = q.div_t[3];
		endcase
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------

	// Optional words come out of reset at their defaults, word four zero
	// Word four at zero leaves the pin released
	// Reset assigns constants only
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			q <= '0;
			q.main_pd <= `PD_RESET;
			q.aux_pd <= `PD_RESET;
			q.e5 <= `DEF_WORD5;
			q.e6 <= `DEF_WORD6;
			q.e7 <= `DEF_WORD7;
		end
		else
		begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs, all from flops
	// ------------------------------------------------------------------------
	// Plain wires from the state flops
	assign WORD3 = q.w3;
	assign WORD4 = q.w4;
	assign WORD5 = q.e5;
	assign WORD6 = q.e6;
	assign WORD7 = q.e7;
	assign FRAC22 = q.w3[`ACC_WORD5];
	assign MAIN_PD = q.main_pd;
	assign AUX_PD = q.aux_pd;
	assign TEST_LOCK_O = q.pin_o;
	assign TEST_LOCK_OE = q.pin_oe;

endmodule

// ==== src/synth_cfg_host.sv ====
// Purpose: Host end: APB register slave that shifts 24-bit words onto the serial link
// Assumes: Software writes words zero to four before relying on the synthesizer
// Notes:   A data write while busy stalls the bus until the link is idle
`timescale 1ns/100ps
`include "synth_regs.svh"

module synth_cfg_host
(
	// Clock and reset
	input  wire logic                CLK,
	input  wire logic                NRST,
	// APB slave
	input  wire logic                PSEL,
	input  wire logic                PENABLE,
	input  wire logic                PWRITE,
	input  wire logic [`ADDR_W-1:0]  PADDR,
	input  wire logic [31:0]         PWDATA,
	output logic [31:0]              PRDATA,
	output logic                     PREADY,
	output logic                     PSLVERR,
	// Interrupt
	output logic                     IRQ,
	// Serial link
	synth_link_if.host               LINK
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	synth_pkg::host_state_s q;
	synth_pkg::host_state_s d;

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------

	// Bus slave, interrupt bits and serial shifter in one pass
	always_comb
	begin
		logic                 wr_data;
		logic                 access;
		logic [`WORD_MSB:0]   w;
		logic [31:0]          rd;
		logic                 mapped;
		logic [`INT_W-1:0]    ev;
		wr_data = PWRITE && (PADDR == `OFF_DATA);
		access = PSEL & PENABLE & q.pready;
		w = PWDATA[`WORD_MSB:0];
		rd = 32'h0000_0000;
		mapped = 1'b1;
		ev = '0;
		d = q;
		d.pready = 1'b0;

		// Read mux; unmapped reads zero with an error
		unique case (PADDR)
			`OFF_DATA:     rd = {8'h00, q.shift};
			`OFF_STATUS:   rd = {16'h0000, q.seen, 6'h00, &q.seen[4:0],
			                     q.st != synth_pkg::H_IDLE};
			`OFF_INT_STAT: rd = {30'h0000_0000, q.ist};
			`OFF_INT_MASK: rd = {30'h0000_0000, q.imask};
			default:       mapped = 1'b0;
		endcase

		// Answer one cycle after setup; hold off a data write while shifting
		if (PSEL && !q.pready && !(wr_data && q.st != synth_pkg::H_IDLE))
		begin
			d.pready = 1'b1;
			d.prdata = rd;
			d.pslverr = ~mapped;
		end

		// Serial shifter: data set with clock low, sampled on the rise
		unique case (q.st)
			synth_pkg::H_IDLE:
			begin
				d.le = 1'b0;
				d.sclk = 1'b0;
			end
			synth_pkg::H_LOW:
			begin
				d.cnt = q.cnt - 3'h1;
				if (q.cnt == 3'h0)
				begin
					d.st = synth_pkg::H_HIGH;
					d.sclk = 1'b1;
					d.cnt = 3'(`SCLK_HALF - 1);
				end
			end
			synth_pkg::H_HIGH:
			begin
				d.cnt = q.cnt - 3'h1;
				if (q.cnt == 3'h0)
				begin
					d.sclk = 1'b0;
					d.cnt = 3'(`SCLK_HALF - 1);
					if (q.nbit == `LAST_BIT)
					begin
						d.st = synth_pkg::H_LATCH;
						d.le = 1'b1;
					end
					else
					begin
						d.st = synth_pkg::H_LOW;
						d.nbit = q.nbit + `BIT_NUM_W'(1);
						d.sdat = q.shift[`WORD_MSB-1];
					end
				end
			end
			synth_pkg::H_LATCH:
			begin
				d.cnt = q.cnt - 3'h1;
				if (q.cnt == 3'h0)
				begin
					d.st = synth_pkg::H_IDLE;
					d.le = 1'b0;
					ev[`INT_SENT] = 1'b1;
					d.seen[synth_pkg::word_index(q.shift[`CODE_MSB:0])] = 1'b1;
				end
			end
		endcase

		// Register writes take effect at the completing edge only
		if (access && PWRITE)
		begin
			unique case (PADDR)
				`OFF_DATA:
				begin
					// Word three always goes out with its must-be-one bit set
					if (w[`CODE_MSB:0] == `CODE_WORD3)
					begin
						ev[`INT_FORCED] = ~w[`ACC_MUST_ONE];
						w[`ACC_MUST_ONE] = 1'b1;
					end
					d.st = synth_pkg::H_LOW;
					d.shift = w;
					d.sdat = w[`WORD_MSB];
					d.nbit = '0;
					d.cnt = 3'(`SCLK_HALF - 1);
				end
				`OFF_INT_STAT: d.ist = q.ist & ~PWDATA[`INT_W-1:0];
				`OFF_INT_MASK: d.imask = PWDATA[`INT_W-1:0];
				default:       d.pslverr = q.pslverr;
			endcase
		end

		// Rotate all 24 bits so word and code are whole again at latch
		if (q.st == synth_pkg::H_HIGH && q.cnt == 3'h0)
		begin
			d.shift = {q.shift[`WORD_MSB-1:0], q.shift[`WORD_MSB]};
		end

		// Events set after the clear so a same-cycle event is kept
		d.ist = d.ist | ev;
		d.irq = |(q.ist & q.imask);
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs, all from flops
	// ------------------------------------------------------------------------
	assign PRDATA = q.prdata;
	assign PREADY = q.pready;
	assign PSLVERR = q.pslverr;
	assign IRQ = q.irq;
	assign LINK.sclk = q.sclk;
	assign LINK.sdata = q.sdat;
	assign LINK.le = q.le;

endmodule

// ==== src/synth_link_if.sv ====
// Purpose: Three-wire serial link between the host end and the device end
// Assumes: Host drives all three wires
// Notes:   Word is shifted MSB first, taken on the latch-enable rise
`timescale 1ns/100ps

interface synth_link_if;
	logic sclk;    // Serial clock
	logic sdata;   // Serial data
	logic le;      // Latch enable

	modport host (output sclk, output sdata, output le);
	modport dev  (input sclk, input sdata, input le);
endinterface

// ==== src/synth_pkg.sv ====
// Purpose: Types shared by the device and host ends of the configuration link
// Assumes: synth_regs.svh supplies the word, code, bit-number and interrupt widths
// Notes:   Each end keeps all of its state in one packed struct
`include "synth_regs.svh"

package synth_pkg;

	// ------------------------------------------------------------------------
	// Word index from address code: code with bit 0 clear is word zero
	// ------------------------------------------------------------------------
	function automatic logic [2:0] word_index(input logic [`CODE_MSB:0] code);
		word_index = code[0] ? code[3:1] : 3'h0;
	endfunction

	// Host shift states, Gray along idle, low, high, latch
	typedef enum logic [1:0]
	{
		H_IDLE  = 2'b00,
		H_LOW   = 2'b01,
		H_HIGH  = 2'b11,
		H_LATCH = 2'b10
	} host_st_e;

	typedef struct packed
	{
		logic [2:0]           sclk_r;
		logic [1:0]           sdat_r;
		logic [2:0]           le_r;
		logic [1:0]           ce_r;
		logic [`WORD_MSB:0]   shift;
		logic                 main_pd;
		logic                 aux_pd;
		logic [`WORD_MSB:0]   w3;
		logic [`WORD_MSB:0]   w4;
		logic [`WORD_MSB:0]   w5;
		logic [`WORD_MSB:0]   w6;
		logic [`WORD_MSB:0]   w7;
		logic [`WORD_MSB:0]   e5;
		logic [`WORD_MSB:0]   e6;
		logic [`WORD_MSB:0]   e7;
		logic [3:0]           div_p;
		logic [3:0]           div_t;
		logic                 pin_o;
		logic                 pin_oe;
	} dev_state_s;

	typedef struct packed
	{
		host_st_e             st;
		logic [2:0]           cnt;
		logic [`BIT_NUM_W-1:0] nbit;
		logic [`WORD_MSB:0]   shift;
		logic                 sclk;
		logic                 sdat;
		logic                 le;
		logic [7:0]           seen;
		logic [`INT_W-1:0]    ist;
		logic [`INT_W-1:0]    imask;
		logic                 pready;
		logic                 pslverr;
		logic [31:0]          prdata;
		logic                 irq;
	} host_state_s;

endpackage

// ==== src/synth_regs.svh ====
// Purpose: Shared constants for the synthesizer configuration link and both of its ends
// Assumes: 24-bit serial words, address code in bits 3:0
// Notes:   Definitions only
`ifndef SYNTH_REGS_SVH
`define SYNTH_REGS_SVH

// ----------------------------------------------------------------------------
// Word format
// ----------------------------------------------------------------------------
`define WORD_W          24
`define CODE_MSB        3
`define WORD_MSB        23
`define BIT_NUM_W       5
`define LAST_BIT        5'h17
`define CODE_WORD1      4'h3
`define CODE_WORD3      4'h7
`define PD_BIT          23
`define PD_RESET        1'h1

// ----------------------------------------------------------------------------
// Word three access-select bits
// ----------------------------------------------------------------------------
`define ACC_MUST_ONE    20
`define ACC_WORD5       21
`define ACC_WORD6       22
`define ACC_WORD7       23

// ----------------------------------------------------------------------------
// Forced default words for words five, six and seven
// ----------------------------------------------------------------------------
`define DEF_WORD5       24'h00_000B
`define DEF_WORD6       24'h00_000D
`define DEF_WORD7       24'h00_090F

// ----------------------------------------------------------------------------
// Word four layout
// ----------------------------------------------------------------------------
`define W4_AUTO_PU      23
`define W4_FIXED_HI     22
`define W4_FIXED_LO     18
`define W4_FIXED_VAL    5'h08
`define W4_DITHER_HI    17
`define W4_DITHER_LO    16
`define W4_MOD_HI       15
`define W4_MOD_LO       14
`define W4_ZERO         13
`define W4_DOUBLER      12
`define W4_OSC_BUF      11
`define W4_AUX_POL      10
`define W4_MAIN_POL     9
`define W4_AUX_PRESC    8
`define W4_SEL_HI       7
`define W4_SEL_LO       4

// ----------------------------------------------------------------------------
// Test pin selector codes
// ----------------------------------------------------------------------------
`define SEL_HIZ         4'h0
`define SEL_GP_HIGH     4'h1
`define SEL_GP_LOW      4'h2
`define SEL_DLD_BOTH    4'h3
`define SEL_DLD_MAIN    4'h4
`define SEL_DLD_AUX     4'h5
`define SEL_ALD_BOTH_OD 4'h6
`define SEL_ALD_MAIN_OD 4'h7
`define SEL_ALD_AUX_OD  4'h8
`define SEL_ALD_BOTH_PP 4'h9
`define SEL_ALD_MAIN_PP 4'hA
`define SEL_ALD_AUX_PP  4'hB
`define SEL_AUX_REF     4'hC
`define SEL_AUX_FB      4'hD
`define SEL_MAIN_REF    4'hE
`define SEL_MAIN_FB     4'hF

// ----------------------------------------------------------------------------
// Host timing and APB map
// ----------------------------------------------------------------------------
`define CLK_HZ          50_000_000
`define SCLK_MAX_HZ     20_000_000
`define SCLK_HALF       ((`CLK_HZ + 2 * `SCLK_MAX_HZ - 1) / (2 * `SCLK_MAX_HZ))
`define ADDR_W          12
`define OFF_DATA        12'h000
`define OFF_STATUS      12'h004
`define OFF_INT_STAT    12'h008
`define OFF_INT_MASK    12'h00C
`define ST_BUSY         0
`define ST_INIT_DONE    1
`define ST_SEEN_LO      8
`define INT_SENT        0
`define INT_W           2
`define INT_FORCED      1

`endif

// ==== tb/synth_cfg_assertions.sv ====
// Purpose: Checks on the serial wires and the device outputs of the config link
// Assumes: Device outputs are flops on CLK
// Notes:   Pin checks wait until selector and lock inputs hold for a cycle
`timescale 1ns/100ps
`include "synth_regs.svh"

module synth_cfg_assertions
(
	// Clock and reset
	input wire logic        CLK,
	input wire logic        NRST,
	// Link wires
	input wire logic        sclk,
	input wire logic        sdata,
	input wire logic        le,
	// Device outputs
	input wire logic [23:0] WORD3,
	input wire logic [23:0] WORD4,
	input wire logic [23:0] WORD5,
	input wire logic [23:0] WORD6,
	input wire logic [23:0] WORD7,
	input wire logic        FRAC22,
	input wire logic        TEST_LOCK_O,
	input wire logic        TEST_LOCK_OE,
	// Lock inputs
	input wire logic        DLOCK_MAIN,
	input wire logic        DLOCK_AUX,
	input wire logic        ALOCK_MAIN,
	input wire logic        ALOCK_AUX
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	// ------------------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------------------
	logic [4:0] nrise_q;
	logic       sclk_q;
	logic [7:0] hold_q;
	wire  [3:0] sel = WORD4[7:4];
	wire  [3:0] lk  = {DLOCK_MAIN, DLOCK_AUX, ALOCK_MAIN, ALOCK_AUX};
	wire        steady = ({sel, lk} == hold_q);

	// Count serial clock rises per frame; pin output lags its cause by one cycle
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			nrise_q <= 5'h00;
			sclk_q  <= 1'b0;
			hold_q  <= 8'h00;
		end
		else
		begin
			nrise_q <= le ? 5'h00 : nrise_q + {4'h0, sclk & ~sclk_q};
			sclk_q  <= sclk;
			hold_q  <= {sel, lk};
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	AST_FRAME_24: assert property ($rose(le) |-> nrise_q == 5'h18)
		else $error("frame not 24 clocks");
	AST_LE_LOW: assert property (le |-> !sclk)
		else $error("latch with clock high");
	AST_DATA_HOLD: assert property (sclk && $past(sclk) |-> $stable(sdata))
		else $error("data moved while clock high");
	AST_MUST_ONE: assert property ($changed(WORD3) |-> WORD3[20])
		else $error("word three bit 20 clear");
	AST_DEF5: assert property (!WORD3[21] && !$past(WORD3[21]) |-> WORD5 == `DEF_WORD5)
		else $error("word five not default");
	AST_DEF6: assert property (!WORD3[22] && !$past(WORD3[22]) |-> WORD6 == `DEF_WORD6)
		else $error("word six not default");
	AST_DEF7: assert property (!WORD3[23] && !$past(WORD3[23]) |-> WORD7 == `DEF_WORD7)
		else $error("word seven not default");
	AST_RETAKE: assert property ($fell(WORD3[22]) |=> WORD6 == `DEF_WORD6)
		else $error("default not retaken");
	AST_FRAC: assert property (!FRAC22 && !$past(FRAC22) |-> WORD5[23:4] == 20'h0_0000)
		else $error("fraction mode wrong");
	AST_PIN_HIZ: assert property (steady && sel == 4'h0 |-> !TEST_LOCK_OE)
		else $error("pin driven in code zero");
	AST_PIN_GP: assert property (steady && (sel == 4'h1 || sel == 4'h2)
		|-> TEST_LOCK_OE && TEST_LOCK_O == sel[0])
		else $error("general output wrong");
	AST_PIN_DLD: assert property (steady && sel inside {4'h3, 4'h4, 4'h5} |-> TEST_LOCK_OE
		&& TEST_LOCK_O == (sel == 4'h3 ? lk[3] & lk[2] : sel == 4'h4 ? lk[3] : lk[2]))
		else $error("digital lock wrong");
	AST_PIN_OD: assert property (steady && sel inside {4'h6, 4'h7, 4'h8} |-> !TEST_LOCK_O
		&& TEST_LOCK_OE == !(sel == 4'h6 ? lk[1] & lk[0] : sel == 4'h7 ? lk[1] : lk[0]))
		else $error("open drain lock wrong");
	AST_PIN_PP: assert property (steady && sel inside {4'h9, 4'hA, 4'hB} |-> TEST_LOCK_OE
		&& TEST_LOCK_O == (sel == 4'h9 ? lk[1] & lk[0] : sel == 4'hA ? lk[1] : lk[0]))
		else $error("analog lock wrong");
	AST_PIN_DIV: assert property (steady && sel[3:2] == 2'b11 |-> TEST_LOCK_OE)
		else $error("divider output not driven");
endmodule

// ==== tb/synth_config_access_and_test_mux_tb_top.sv ====
// Purpose: Host and device ends joined, driven over APB
// Assumes: Each word lands on the device within a few cycles of busy clearing
// Notes:   Random data from a fixed seed
`timescale 1ns/100ps
`include "synth_regs.svh"

module synth_config_access_and_test_mux_tb_top;
	logic        clk, nrst, ce, psel, penable, pwrite, pready, pslverr, irq, err;
	logic        frac22, main_pd, aux_pd, pin_o, pin_oe;
	logic [3:0]  lk, div_pulse;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] word3, word4, word5, word6, word7, w;
	logic [23:0] dw [0:2];
	logic [1:0]  e;
	int          n_errors, tests_run;

	// ------------------------------------------------------------------------
	// Ends and checker
	// ------------------------------------------------------------------------
	synth_link_if synth_link_if_i ();
	synth_cfg_host synth_cfg_host_i (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .IRQ(irq), .LINK(synth_link_if_i));
	synth_cfg_device synth_cfg_device_i (.CLK(clk), .NRST(nrst), .LINK(synth_link_if_i),
		.CE(ce), .DLOCK_MAIN(lk[3]), .DLOCK_AUX(lk[2]), .ALOCK_MAIN(lk[1]), .ALOCK_AUX(lk[0]),
		.DIV_PULSE(div_pulse), .WORD3(word3), .WORD4(word4), .WORD5(word5), .WORD6(word6),
		.WORD7(word7), .FRAC22(frac22), .MAIN_PD(main_pd), .AUX_PD(aux_pd),
		.TEST_LOCK_O(pin_o), .TEST_LOCK_OE(pin_oe));
	synth_cfg_assertions synth_cfg_assertions_i (.CLK(clk), .NRST(nrst),
		.sclk(synth_link_if_i.sclk), .sdata(synth_link_if_i.sdata), .le(synth_link_if_i.le),
		.WORD3(word3), .WORD4(word4), .WORD5(word5), .WORD6(word6), .WORD7(word7),
		.FRAC22(frac22), .TEST_LOCK_O(pin_o), .TEST_LOCK_OE(pin_oe), .DLOCK_MAIN(lk[3]),
		.DLOCK_AUX(lk[2]), .ALOCK_MAIN(lk[1]), .ALOCK_AUX(lk[0]));

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic logic [3:0] code(input logic [2:0] n);
		code = (n == 3'h0) ? 4'h0 : {n, 1'b1};
	endfunction

	// Word four keeps its fixed pattern and zero bit; dither never reserved
	function automatic logic [23:0] mk4(input logic ap, input logic [3:0] s, input logic [8:0] r);
		mk4 = {ap, `W4_FIXED_VAL, 1'b0, r[8], r[7:6], 1'b0, r[4:0], s, 4'h9};
	endfunction

	// Pin enable and level from selector and locks {dm, da, am, aa}
	function automatic logic [1:0] pin_exp(input logic [3:0] s, input logic [3:0] l);
		case (s)
			4'h0: pin_exp = 2'b00;
			4'h1: pin_exp = 2'b11;
			4'h2: pin_exp = 2'b10;
			4'h3: pin_exp = {1'b1, l[3] & l[2]};
			4'h4: pin_exp = {1'b1, l[3]};
			4'h5: pin_exp = {1'b1, l[2]};
			4'h6: pin_exp = {~(l[1] & l[0]), 1'b0};
			4'h7: pin_exp = {~l[1], 1'b0};
			4'h8: pin_exp = {~l[0], 1'b0};
			4'h9: pin_exp = {1'b1, l[1] & l[0]};
			4'hA: pin_exp = {1'b1, l[1]};
			4'hB: pin_exp = {1'b1, l[0]};
			default: pin_exp = 2'b10;
		endcase
	endfunction

	task automatic chk_w(input string n, input logic [23:0] x, input logic [23:0] g);
		tests_run++;
		if (g !== x)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic chk_b(input string n, input logic x, input logic g);
		tests_run++;
		if (g !== x)
		begin
			n_errors++;
			$display("BAD %s expected %b seen %b", n, x, g);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Send one word, then wait for the link to go idle and the device to store it
	task automatic send(input logic [2:0] n, input logic [23:0] d);
		apb(1'b1, `OFF_DATA, {8'h00, d[23:4], code(n)});
		do apb(1'b0, `OFF_STATUS, 32'h0); while (rd[`ST_BUSY] !== 1'b0);
		repeat (6) @(posedge clk);
	endtask

	task automatic chk_opt(input logic [2:0] a);
		chk_w("word5", a[0] ? dw[0] : `DEF_WORD5, word5);
		chk_w("word6", a[1] ? dw[1] : `DEF_WORD6, word6);
		chk_w("word7", a[2] ? dw[2] : `DEF_WORD7, word7);
	endtask

	task automatic print_verdict();
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------------------------------------------------
	// Clock, divider pulses, watchdog
	// ------------------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Divider outputs wander freely
	always @(posedge clk)
		div_pulse <= 4'($urandom);

	// Divider halving model, one extra flop to match the pin
	logic [3:0] dp_q, dt_q, dt2_q;
	always @(posedge clk or negedge nrst)
		if (!nrst) {dp_q, dt_q, dt2_q} <= 12'h000;
		else {dp_q, dt_q, dt2_q} <= {div_pulse, dt_q ^ (div_pulse & ~dp_q), dt_q};

	// Whole run needs about 9000 cycles
	initial
	begin
		repeat (60000) @(posedge clk);
		n_errors++;
		print_verdict();
	end

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial
	begin
		{nrst, ce, psel, penable, pwrite, lk} = 9'h080;
		paddr = 12'h000;
		pwdata = 32'h0;
		void'($urandom(32'h93fe));
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk_opt(3'h0);
		chk_b("pin_oe", 1'b0, pin_oe);
		// Mandatory words; word three sent with bit 20 clear
		send(3'd0, 24'($urandom));
		send(3'd1, 24'($urandom));
		send(3'd2, 24'($urandom));
		send(3'd3, 24'h00_0007);
		chk_b("must_one", 1'b1, word3[20]);
		send(3'd4, mk4(1'b0, 4'h0, 9'($urandom)));
		apb(1'b0, `OFF_STATUS, 32'h0);
		chk_b("init_done", 1'b1, rd[`ST_INIT_DONE]);
		apb(1'b0, `OFF_INT_STAT, 32'h0);
		chk_b("forced", 1'b1, rd[`INT_FORCED]);
		// Every access pattern; cleared words must drop back at once
		for (int a = 0; a < 8; a++)
		begin
			w = {a[2:0], 1'b1, 16'($urandom), 4'h7};
			send(3'd3, w);
			chk_w("word3", w, word3);
			chk_opt(a[2:0]);
			chk_b("frac22", a[0], frac22);
			for (int k = 0; k < 3; k++)
			begin
				dw[k] = {20'($urandom), code(3'(k + 5))};
				send(3'(k + 5), dw[k]);
			end
			chk_opt(a[2:0]);
		end
		// Every selector code, twice, with random lock levels
		for (int s = 0; s < 32; s++)
		begin
			lk <= 4'($urandom);
			w = mk4(1'b0, s[3:0], 9'($urandom));
			send(3'd4, w);
			chk_w("word4", {w[23:4], 4'h0}, {word4[23:4], 4'h0});
			e = pin_exp(s[3:0], lk);
			chk_b("pin_oe", e[1], pin_oe);
			if (e[1] && s[3:2] != 2'b11) chk_b("pin_o", e[0], pin_o);
			if (s[3:2] == 2'b11) chk_b("pin_div", dt2_q[s[1:0]], pin_o);
		end
		// Auto power-up, enabled then blocked by chip enable
		for (int c = 1; c >= 0; c--)
		begin
			ce <= c[0];
			send(3'd1, {1'b1, 23'($urandom)});
			send(3'd2, {1'b1, 23'($urandom)});
			send(3'd4, mk4(1'b1, 4'h0, 9'($urandom)));
			send(3'd0, 24'($urandom));
			chk_b("main_pd", ~c[0], main_pd);
			chk_b("aux_pd", ~c[0], aux_pd);
		end
		// Interrupt masked, unmasked, cleared; then an unmapped read
		chk_b("irq_masked", 1'b0, irq);
		apb(1'b1, `OFF_INT_MASK, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk_b("irq_on", 1'b1, irq);
		apb(1'b1, `OFF_INT_STAT, 32'h0000_0003);
		repeat (2) @(posedge clk);
		chk_b("irq_off", 1'b0, irq);
		apb(1'b0, 12'h010, 32'h0);
		chk_b("slverr", 1'b1, err);
		chk_w("unmapped", 24'h0, rd[23:0]);
		print_verdict();
	end
endmodule
